// ### efsbl_pkg.sv
/*
  Shared constants and types for the earth fault stage block and log.
  Assumes a 25 MHz pclk and a one millisecond processing cycle.
*/
package efsbl_pkg;
  localparam int NSTG = 4;
  localparam int REC_DEPTH = 12;
  localparam int NSIG = 7;
  localparam int NEVT = 2 * NSIG;
  localparam int NKIND = 3;
  localparam int MSW = 21;
  localparam int MEASW = 16;
  localparam int HLW = 13;
  localparam int CNTW = 16;
  localparam int INV_SH = 4;
  localparam int CLK_HZ = 25000000;
  localparam int PROC_CYCLE_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * PROC_CYCLE_MS;
  localparam logic [HLW-1:0] HLIM_RST = 13'h0001;
  localparam logic [HLW-1:0] HLIM_MAX = 13'h1388;
  localparam logic [MSW-1:0] DELAY_RST = 21'h000064;
  localparam logic [MSW-1:0] MINT_RST = 21'h000028;
  localparam logic [MSW-1:0] REL_RST = 21'h000032;
  localparam logic [NEVT-1:0] EVMASK_RST = 14'h3fff;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_TIME = 12'h004;
  localparam logic [11:0] OFS_RSEL = 12'h008;
  localparam logic [11:0] OFS_WPTR = 12'h00c;
  localparam logic [11:0] OFS_CNT = 12'h040;
  localparam logic [11:0] OFS_REC = 12'h080;
  localparam logic [11:0] OFS_STG = 12'h100;
  localparam logic [11:0] STG_SPAN = 12'h080;
  localparam logic [11:0] CNT_SPAN = 12'h030;
  localparam logic [11:0] REC_SPAN = 12'h01c;
  localparam int WIDX_LSB = 2;
  localparam int STG_LSB = 5;
  localparam int SLOT_LSB = 4;
  localparam logic [2:0] SR_CFG = 3'h0;
  localparam logic [2:0] SR_HLIM = 3'h1;
  localparam logic [2:0] SR_DELAY = 3'h2;
  localparam logic [2:0] SR_MINT = 3'h3;
  localparam logic [2:0] SR_REL = 3'h4;
  localparam logic [2:0] SR_EVMASK = 3'h5;
  localparam int CFG_INRUSH_BIT = 0;
  localparam int CFG_INV_BIT = 1;
  typedef enum logic [1:0] {COND_NORMAL, COND_STARTED, COND_TRIPPED, COND_BLOCKED} efsbl_cond_t;
  typedef struct packed {
    logic [3:0] code;
    logic [2:0] group;
    logic [1:0] gnd;
    logic [31:0] ts;
    logic [MEASW-1:0] pre20;
    logic [MEASW-1:0] fault;
    logic [MEASW-1:0] cap;
    logic [MEASW-1:0] res;
    logic [MEASW-1:0] upct;
    logic [MEASW-1:0] uvolt;
    logic [MEASW-1:0] angle;
    logic [MEASW-1:0] pre200;
    logic [MSW-1:0] remain;
  } efsbl_rec_t;
  typedef struct packed {
    logic inrush_en;
    logic inverse_delay_type;
    logic [HLW-1:0] hlim;
    logic [MSW-1:0] delay;
    logic [MSW-1:0] mint;
    logic [MSW-1:0] rel;
    logic [NEVT-1:0] evmask;
  } efsbl_cfg_t;
endpackage

// ### efsbl_satcnt.sv
/*
  Saturating event counter.
  Assumes inc is a one-cycle pulse in the pclk domain.
*/
`timescale 1ns/1ns
module efsbl_satcnt (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic inc,
  output logic [efsbl_pkg::CNTW-1:0] count
);
  typedef struct packed {
    logic [efsbl_pkg::CNTW-1:0] cnt;
  } efsbl_cnt_st_t;
  efsbl_cnt_st_t q, n;

  always_comb begin
    n = q;
    if (inc && q.cnt != '1) begin
      n.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign count = q.cnt;
endmodule

// ### efsbl_stage.sv
/*
  One directional residual-current stage: block gating, start, trip, release.
  Assumes tick is a one-cycle pulse marking each processing cycle.
*/
`timescale 1ns/1ns
module efsbl_stage (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic pickup,
  input wire logic pick_res,
  input wire logic pick_reac,
  input wire logic block_in,
  input wire logic [efsbl_pkg::HLW-1:0] harm_ratio,
  input wire logic [7:0] cur_ratio,
  input wire efsbl_pkg::efsbl_cfg_t cfg,
  output logic start,
  output logic trip,
  output logic blocked,
  output logic [3:0] comp,
  output logic [efsbl_pkg::MSW-1:0] remain,
  output efsbl_pkg::efsbl_cond_t cond
);
  localparam int ACCW = efsbl_pkg::MSW + efsbl_pkg::INV_SH;
  typedef struct packed {
    logic start;
    logic trip;
    logic blocked;
    logic [3:0] comp;
    logic [ACCW-1:0] acc;
    logic [efsbl_pkg::MSW-1:0] elapsed;
    logic [efsbl_pkg::MSW-1:0] rel;
    logic [efsbl_pkg::MSW-1:0] remain;
    efsbl_pkg::efsbl_cond_t cond;
  } efsbl_stg_st_t;
  efsbl_stg_st_t q, n;

  always_comb begin
    logic blk;
    logic [ACCW-1:0] step;
    blk = block_in | (cfg.inrush_en & (harm_ratio >= cfg.hlim));
    step = cfg.inverse_delay_type ? ACCW'(cur_ratio) : ACCW'(1 << efsbl_pkg::INV_SH);
    n = q;
    if (tick) begin
      if (pickup && blk) begin
        n.blocked = 1'b1;
        n.start = 1'b0;
        n.trip = 1'b0;
      end else if (pickup) begin
        n.blocked = 1'b0;
        n.start = 1'b1;
        n.rel = '0;
      end else begin
        n.blocked = 1'b0;
        n.start = 1'b0;
        n.trip = 1'b0;
      end
      if (n.start && !q.trip) begin
        n.acc = q.acc + step;
        if (q.elapsed != '1) begin
          n.elapsed = q.elapsed + 21'h000001;
        end
        if (n.acc >= (ACCW'(cfg.delay) << efsbl_pkg::INV_SH) &&
            (!cfg.inverse_delay_type || n.elapsed >= cfg.mint)) begin
          n.trip = 1'b1;
        end
      end else if (!n.start) begin
        if (q.rel >= cfg.rel) begin
          n.acc = '0;
          n.elapsed = '0;
        end else begin
          n.rel = q.rel + 21'h000001;
        end
      end
      n.remain = (n.start && cfg.delay > n.elapsed) ? cfg.delay - n.elapsed : '0;
      n.comp = {n.trip & pick_reac, n.trip & pick_res, n.start & pick_reac, n.start & pick_res};
      if (n.blocked) begin
        n.cond = efsbl_pkg::COND_BLOCKED;
      end else if (n.trip) begin
        n.cond = efsbl_pkg::COND_TRIPPED;
      end else if (n.start) begin
        n.cond = efsbl_pkg::COND_STARTED;
      end else begin
        n.cond = efsbl_pkg::COND_NORMAL;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign start = q.start;
  assign trip = q.trip;
  assign blocked = q.blocked;
  assign comp = q.comp;
  assign remain = q.remain;
  assign cond = q.cond;
endmodule

// ### efsbl_top.sv
/*
  Four directional residual-current stages with block gating, events,
  saturating counters and per-stage fault record logs behind an APB slave.
  Assumes all inputs are synchronous to pclk and measurement inputs are
  already scaled by the measurement path.
*/
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// - Block input sampled once per processing cycle.
// - Inrush blocking selectable, off after reset.
// - Block when harmonic ratio reaches set limit.
// - Unblocked pick-up asserts start, begins timing.
// - Blocked pick-up asserts blocked, nothing further.
// - Block during start runs normal release.
// - Fixed or inverse delay with minimum time.
// - Per-event choice of on/off events logged.
// - Every event carries its change time stamp.
// - Counters for start, trip and blocked.
// - Four independent stages, separate logs.
// - On/off events for all seven stage signals.
// - Twelve newest records kept, oldest overwritten.
// - Record captured on start/trip/blocked rising.
// - Record holds time, currents, voltages, angle, group.
// - Stage outputs available as discrete signals.
// - Condition: normal, started, tripped or blocked.
module efsbl_top #(
  parameter int TICK_CYCLES = efsbl_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [efsbl_pkg::NSTG-1:0] pickup,
  input wire logic [efsbl_pkg::NSTG-1:0] pick_res,
  input wire logic [efsbl_pkg::NSTG-1:0] pick_reac,
  input wire logic [efsbl_pkg::NSTG-1:0] block_in,
  input wire logic [efsbl_pkg::NSTG-1:0][efsbl_pkg::HLW-1:0] harm_ratio,
  input wire logic [efsbl_pkg::NSTG-1:0][7:0] cur_ratio,
  input wire logic [efsbl_pkg::MEASW-1:0] i0_pre20,
  input wire logic [efsbl_pkg::MEASW-1:0] i0_fault,
  input wire logic [efsbl_pkg::MEASW-1:0] i0_cap,
  input wire logic [efsbl_pkg::MEASW-1:0] i0_res,
  input wire logic [efsbl_pkg::MEASW-1:0] u0_pct,
  input wire logic [efsbl_pkg::MEASW-1:0] u0_volt,
  input wire logic [efsbl_pkg::MEASW-1:0] i0_angle,
  input wire logic [efsbl_pkg::MEASW-1:0] i0_pre200,
  input wire logic [2:0] set_group,
  input wire logic [1:0] gnd_type,
  output logic [efsbl_pkg::NSTG-1:0] start_o,
  output logic [efsbl_pkg::NSTG-1:0] trip_o,
  output logic [efsbl_pkg::NSTG-1:0] blocked_o,
  output logic [efsbl_pkg::NSTG-1:0] res_start_o,
  output logic [efsbl_pkg::NSTG-1:0] reac_start_o,
  output logic [efsbl_pkg::NSTG-1:0] res_trip_o,
  output logic [efsbl_pkg::NSTG-1:0] reac_trip_o,
  output efsbl_pkg::efsbl_cond_t [efsbl_pkg::NSTG-1:0] cond_o,
  output logic evt_valid,
  output logic [1:0] evt_stage,
  output logic [3:0] evt_code,
  output logic [31:0] evt_time
);
  localparam int NSTG = efsbl_pkg::NSTG;
  localparam int NSIG = efsbl_pkg::NSIG;
  localparam int NKIND = efsbl_pkg::NKIND;
  localparam int REC_DEPTH = efsbl_pkg::REC_DEPTH;

  typedef struct packed {
    efsbl_pkg::efsbl_cfg_t [NSTG-1:0] cfg;
    logic [15:0] div;
    logic tick;
    logic [31:0] now;
    logic [NSTG-1:0][NSIG-1:0] prev;
    logic [NSTG-1:0][efsbl_pkg::NEVT-1:0] pend;
    logic [NSTG-1:0][31:0] ts;
    logic [NSTG-1:0][3:0] wptr;
    efsbl_pkg::efsbl_rec_t [NSTG-1:0][REC_DEPTH-1:0] rec;
    logic [1:0] rs_stg;
    logic [3:0] rs_slot;
    logic ev_v;
    logic [1:0] ev_s;
    logic [3:0] ev_c;
    logic [31:0] ev_t;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } efsbl_top_st_t;

  efsbl_top_st_t q, n;
  logic [NSTG-1:0][NSIG-1:0] lvl;
  logic [NSTG-1:0][3:0] comp;
  logic [NSTG-1:0][efsbl_pkg::MSW-1:0] remain;
  logic [NSTG*NKIND-1:0] inc;
  logic [NSTG*NKIND-1:0][efsbl_pkg::CNTW-1:0] cnt;

  // Each stage is a separate instance so no state is shared between them.
  for (genvar s = 0; s < NSTG; s++) begin : g_stg
    efsbl_stage u_stage (
      .pclk(pclk),
      .presetn(presetn),
      .tick(q.tick),
      .pickup(pickup[s]),
      .pick_res(pick_res[s]),
      .pick_reac(pick_reac[s]),
      .block_in(block_in[s]),
      .harm_ratio(harm_ratio[s]),
      .cur_ratio(cur_ratio[s]),
      .cfg(q.cfg[s]),
      .start(start_o[s]),
      .trip(trip_o[s]),
      .blocked(blocked_o[s]),
      .comp(comp[s]),
      .remain(remain[s]),
      .cond(cond_o[s])
    );
    assign res_start_o[s] = comp[s][0];
    assign reac_start_o[s] = comp[s][1];
    assign res_trip_o[s] = comp[s][2];
    assign reac_trip_o[s] = comp[s][3];
    assign lvl[s] = {comp[s], blocked_o[s], trip_o[s], start_o[s]};
  end

  for (genvar c = 0; c < NSTG * NKIND; c++) begin : g_cnt
    efsbl_satcnt u_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .inc(inc[c]),
      .count(cnt[c])
    );
  end

  always_comb begin
    inc = '0;
    for (int s = 0; s < NSTG; s++) begin
      for (int k = 0; k < NKIND; k++) begin
        inc[s*NKIND+k] = lvl[s][k] & ~q.prev[s][k];
      end
    end
  end

  always_comb begin
    logic [NSIG-1:0] rise;
    logic [NSIG-1:0] fall;
    logic found;
    logic [1:0] as;
    logic [2:0] ar;
    logic [3:0] ai;
    efsbl_pkg::efsbl_rec_t rec;
    efsbl_pkg::efsbl_rec_t rr;
    rise = '0;
    fall = '0;
    found = 1'b0;
    as = paddr[efsbl_pkg::STG_LSB +: 2];
    ar = paddr[efsbl_pkg::WIDX_LSB +: 3];
    ai = paddr[efsbl_pkg::WIDX_LSB +: 4];
    rec = '0;
    rr = (q.rs_slot < 4'(REC_DEPTH)) ? q.rec[q.rs_stg][q.rs_slot] : '0;
    n = q;

    // The processing cycle enable and the millisecond time base.
    n.tick = 1'b0;
    if (q.div == 16'(TICK_CYCLES - 1)) begin
      n.div = '0;
      n.tick = 1'b1;
      n.now = q.now + 32'h00000001;
    end else begin
      n.div = q.div + 16'h0001;
    end

    // Drain one pending event per cycle, lowest stage and code first.
    n.ev_v = 1'b0;
    for (int s = 0; s < NSTG; s++) begin
      for (int e = 0; e < efsbl_pkg::NEVT; e++) begin
        if (!found && q.pend[s][e]) begin
          found = 1'b1;
          n.ev_v = 1'b1;
          n.ev_s = 2'(s);
          n.ev_c = 4'(e);
          n.ev_t = q.ts[s];
          n.pend[s][e] = 1'b0;
        end
      end
    end

    // New events are set after the drain clears, so a set always wins.
    for (int s = 0; s < NSTG; s++) begin
      rise = lvl[s] & ~q.prev[s];
      fall = ~lvl[s] & q.prev[s];
      if ((rise | fall) != '0) begin
        n.ts[s] = q.now;
      end
      for (int j = 0; j < NSIG; j++) begin
        if (rise[j] && q.cfg[s].evmask[2*j]) begin
          n.pend[s][2*j] = 1'b1;
        end
        if (fall[j] && q.cfg[s].evmask[2*j+1]) begin
          n.pend[s][2*j+1] = 1'b1;
        end
      end
      n.prev[s] = lvl[s];

      // Start and trip may rise together, so each kind gets its own slot.
      for (int k = 0; k < NKIND; k++) begin
        if (rise[k]) begin
          rec.code = 4'(2 * k);
          rec.group = set_group;
          rec.gnd = gnd_type;
          rec.ts = q.now;
          rec.pre20 = i0_pre20;
          rec.fault = i0_fault;
          rec.cap = i0_cap;
          rec.res = i0_res;
          rec.upct = u0_pct;
          rec.uvolt = u0_volt;
          rec.angle = i0_angle;
          rec.pre200 = i0_pre200;
          rec.remain = remain[s];
          n.rec[s][n.wptr[s]] = rec;
          if (n.wptr[s] == 4'(REC_DEPTH - 1)) begin
            n.wptr[s] = '0;
          end else begin
            n.wptr[s] = n.wptr[s] + 4'h1;
          end
        end
      end
    end

    // The answer is formed in the first access cycle; pready shows in the second, whose edge completes it.
    if (psel && penable && !q.pready) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      if (paddr == efsbl_pkg::OFS_STATUS) begin
        n.prdata = 32'(cond_o);
      end else if (paddr == efsbl_pkg::OFS_TIME) begin
        n.prdata = q.now;
      end else if (paddr == efsbl_pkg::OFS_RSEL) begin
        n.prdata = 32'({q.rs_stg, q.rs_slot});
      end else if (paddr == efsbl_pkg::OFS_WPTR) begin
        n.prdata = 32'(q.wptr);
      end else if (paddr >= efsbl_pkg::OFS_CNT &&
                   paddr < efsbl_pkg::OFS_CNT + efsbl_pkg::CNT_SPAN &&
                   paddr[1:0] == 2'h0) begin
        n.prdata = 32'(cnt[ai]);
      end else if (paddr >= efsbl_pkg::OFS_REC &&
                   paddr < efsbl_pkg::OFS_REC + efsbl_pkg::REC_SPAN &&
                   paddr[1:0] == 2'h0) begin
        if (ar == 3'h0) begin
          n.prdata = 32'({rr.gnd, 1'b0, rr.group, rr.code});
        end else if (ar == 3'h1) begin
          n.prdata = rr.ts;
        end else if (ar == 3'h2) begin
          n.prdata = {rr.fault, rr.pre20};
        end else if (ar == 3'h3) begin
          n.prdata = {rr.res, rr.cap};
        end else if (ar == 3'h4) begin
          n.prdata = {rr.uvolt, rr.upct};
        end else if (ar == 3'h5) begin
          n.prdata = 32'(rr.remain);
        end else begin
          n.prdata = {rr.pre200, rr.angle};
        end
      end else if (paddr >= efsbl_pkg::OFS_STG &&
                   paddr < efsbl_pkg::OFS_STG + efsbl_pkg::STG_SPAN &&
                   paddr[1:0] == 2'h0 && ar <= efsbl_pkg::SR_EVMASK) begin
        if (ar == efsbl_pkg::SR_CFG) begin
          n.prdata = 32'({q.cfg[as].inverse_delay_type, q.cfg[as].inrush_en});
        end else if (ar == efsbl_pkg::SR_HLIM) begin
          n.prdata = 32'(q.cfg[as].hlim);
        end else if (ar == efsbl_pkg::SR_DELAY) begin
          n.prdata = 32'(q.cfg[as].delay);
        end else if (ar == efsbl_pkg::SR_MINT) begin
          n.prdata = 32'(q.cfg[as].mint);
        end else if (ar == efsbl_pkg::SR_REL) begin
          n.prdata = 32'(q.cfg[as].rel);
        end else begin
          n.prdata = 32'(q.cfg[as].evmask);
        end
      end else begin
        n.pslverr = 1'b1;
      end
    end else begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end

    // Writes land only on the completing edge and never on an error.
    if (psel && penable && q.pready && pwrite && !q.pslverr) begin
      if (paddr == efsbl_pkg::OFS_TIME) begin
        n.now = pwdata;
      end else if (paddr == efsbl_pkg::OFS_RSEL) begin
        n.rs_stg = pwdata[efsbl_pkg::SLOT_LSB +: 2];
        n.rs_slot = pwdata[3:0];
      end else if (paddr >= efsbl_pkg::OFS_STG) begin
        if (ar == efsbl_pkg::SR_CFG) begin
          n.cfg[as].inrush_en = pwdata[efsbl_pkg::CFG_INRUSH_BIT];
          n.cfg[as].inverse_delay_type = pwdata[efsbl_pkg::CFG_INV_BIT];
        end else if (ar == efsbl_pkg::SR_HLIM) begin
          if (pwdata > 32'(efsbl_pkg::HLIM_MAX)) begin
            n.cfg[as].hlim = efsbl_pkg::HLIM_MAX;
          end else begin
            n.cfg[as].hlim = pwdata[efsbl_pkg::HLW-1:0];
          end
        end else if (ar == efsbl_pkg::SR_DELAY) begin
          n.cfg[as].delay = pwdata[efsbl_pkg::MSW-1:0];
        end else if (ar == efsbl_pkg::SR_MINT) begin
          n.cfg[as].mint = pwdata[efsbl_pkg::MSW-1:0];
        end else if (ar == efsbl_pkg::SR_REL) begin
          n.cfg[as].rel = pwdata[efsbl_pkg::MSW-1:0];
        end else begin
          n.cfg[as].evmask = pwdata[efsbl_pkg::NEVT-1:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      for (int s = 0; s < NSTG; s++) begin
        q.cfg[s].hlim <= efsbl_pkg::HLIM_RST;
        q.cfg[s].delay <= efsbl_pkg::DELAY_RST;
        q.cfg[s].mint <= efsbl_pkg::MINT_RST;
        q.cfg[s].rel <= efsbl_pkg::REL_RST;
        q.cfg[s].evmask <= efsbl_pkg::EVMASK_RST;
      end
    end else begin
      q <= n;
    end
  end

  // The blocker must lead the operate delay; the stage cannot look ahead.
  // Blocking therefore prevents a trip only if sampled no later than the tick on which the delay expires.
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign evt_valid = q.ev_v;
  assign evt_stage = q.ev_s;
  assign evt_code = q.ev_c;
  assign evt_time = q.ev_t;
endmodule

// ### efsbl_far.sv
/*
  Far-side model: pick-up detection and blocking matrix for four stages.
  Assumes the bench sets want_pick and want_blk just after a pclk edge.
*/
`timescale 1ns/1ns
module efsbl_far (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] want_pick,
  input wire logic [3:0] want_blk,
  output logic [3:0] pickup,
  output logic [3:0] pick_res,
  output logic [3:0] pick_reac,
  output logic [3:0] block_in
);
  // Levels are registered, as a real matrix output would be; the bench
  // raises a block well ahead of any delay expiry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pickup <= 4'h0;
      pick_res <= 4'h0;
      pick_reac <= 4'h0;
      block_in <= 4'h0;
    end else begin
      pickup <= want_pick;
      pick_res <= want_pick & 4'h5;
      pick_reac <= want_pick & 4'ha;
      block_in <= want_blk;
    end
  end
endmodule

// ### efsbl_top_asserts.sv
/*
  Checker for the stage outputs, events and APB answer of efsbl_top.
  Assumes one pclk domain and the tick period given by TICK_CYCLES.
*/
`timescale 1ns/1ns
module efsbl_chk #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] pickup,
  input wire logic [3:0] block_in,
  input wire logic [3:0] start_o,
  input wire logic [3:0] trip_o,
  input wire logic [3:0] blocked_o,
  input wire logic [3:0] res_start_o,
  input wire efsbl_pkg::efsbl_cond_t [3:0] cond_o,
  input wire logic evt_valid,
  input wire logic [3:0] evt_code
);
  logic [11:0] outs_r;
  int hold_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles since the stage outputs last moved; saturates to stay cheap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outs_r <= 12'h000;
      hold_r <= TICK_CYCLES;
    end else begin
      outs_r <= {start_o, trip_o, blocked_o};
      if ({start_o, trip_o, blocked_o} != outs_r) begin
        hold_r <= 0;
      end else if (hold_r < TICK_CYCLES) begin
        hold_r <= hold_r + 1;
      end
    end
  end
  out_hold_a: assert property (({start_o, trip_o, blocked_o} != outs_r)
    |-> hold_r >= TICK_CYCLES - 1) else $error("stage outputs moved between ticks");
  start_gate_a: assert property ($rose(start_o[0])
    |-> $past(pickup[0]) && !$past(block_in[0])) else $error("start without open pick-up");
  start_excl_a: assert property ((start_o & blocked_o) == 4'h0)
    else $error("start and blocked together");
  trip_excl_a: assert property ((trip_o & blocked_o) == 4'h0)
    else $error("trip and blocked together");
  res_sub_a: assert property ((res_start_o & ~start_o) == 4'h0)
    else $error("component start without start");
  cond_blk_a: assert property (blocked_o[0] |-> cond_o[0] == efsbl_pkg::COND_BLOCKED)
    else $error("condition not blocked");
  cond_trip_a: assert property (trip_o[2] |-> cond_o[2] == efsbl_pkg::COND_TRIPPED)
    else $error("condition not tripped");
  evt_follow_a: assert property ($rose(start_o[0]) |-> ##[1:12] evt_valid)
    else $error("no event after start");
  code_range_a: assert property (evt_valid |-> evt_code <= 4'hd)
    else $error("event code out of range");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply carries data");
  start_c: cover property ($rose(start_o[0]));
  trip_c: cover property ($rose(trip_o[2]));
  blk_c: cover property ($rose(blocked_o[3]));
endmodule
bind efsbl_top efsbl_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk, .presetn, .psel,
  .penable, .prdata, .pready, .pslverr, .pickup, .block_in, .start_o, .trip_o, .blocked_o,
  .res_start_o, .cond_o, .evt_valid, .evt_code);

// ### tb_earth_fault_stage_block_log.sv
/*
  Self-checking bench for efsbl_top with a far-side model.
  Assumes a shortened tick of 8 pclk cycles.
*/
`timescale 1ns/1ns
module tb_earth_fault_stage_block_log;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, evt_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] want_pick, want_blk, pickup, pick_res, pick_reac, block_in;
  logic [3:0] start_o, trip_o, blocked_o, rs, xs, rt, xt, evt_code;
  logic [3:0][12:0] harm;
  logic [3:0][7:0] cur;
  logic [15:0] meas;
  logic [2:0] grp;
  logic [1:0] gnd, evt_stage;
  logic [31:0] evt_time;
  efsbl_pkg::efsbl_cond_t [3:0] cond_o;
  int n_mismatch = 0;
  int n_tests = 0;
  efsbl_far u_far (.pclk(pclk), .presetn(presetn), .want_pick(want_pick),
    .want_blk(want_blk), .pickup(pickup), .pick_res(pick_res), .pick_reac(pick_reac),
    .block_in(block_in));
  efsbl_top #(.TICK_CYCLES(8)) u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pickup(pickup), .pick_res(pick_res),
    .pick_reac(pick_reac), .block_in(block_in), .harm_ratio(harm), .cur_ratio(cur),
    .i0_pre20(meas), .i0_fault(meas ^ 16'h0f0f), .i0_cap(meas), .i0_res(meas),
    .u0_pct(meas), .u0_volt(meas), .i0_angle(meas), .i0_pre200(meas),
    .set_group(grp), .gnd_type(gnd), .start_o(start_o), .trip_o(trip_o),
    .blocked_o(blocked_o), .res_start_o(rs), .reac_start_o(xs), .res_trip_o(rt),
    .reac_trip_o(xt), .cond_o(cond_o), .evt_valid(evt_valid), .evt_stage(evt_stage),
    .evt_code(evt_code), .evt_time(evt_time));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", e, q);
  endtask
  task automatic wait_cond(input int s, input efsbl_pkg::efsbl_cond_t c);
    int n;
    n = 0;
    while (cond_o[s] !== c && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("condition", {30'h0, c}, {30'h0, cond_o[s]});
  endtask
  task automatic t_regs;
    rdc(12'h100, 32'h0);
    rdc(12'h108, 32'h64);
    rdc(12'h114, 32'h3fff);
    apb(1'b0, 12'h7fc, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
  endtask
  task automatic t_start;
    apb(1'b1, 12'h004, 32'h100);
    want_pick[0] <= 1'b1;
    wait_cond(0, efsbl_pkg::COND_STARTED);
    repeat (2) @(posedge pclk);
    chk("event", 32'h40, {25'h0, evt_valid, evt_stage, evt_code});
    chk("event time", 32'h101, evt_time);
    repeat (2) @(posedge pclk);
    rdc(12'h040, 32'h1);
    apb(1'b1, 12'h008, 32'h0);
    rdc(12'h080, 32'h120);
    rdc(12'h084, 32'h101);
    rdc(12'h088, {meas ^ 16'h0f0f, meas});
    rdc(12'h094, 32'h63);
  endtask
  task automatic t_block_late;
    want_blk[0] <= 1'b1;
    wait_cond(0, efsbl_pkg::COND_BLOCKED);
    chk("start", 32'h0, {31'h0, start_o[0]});
    repeat (4) @(posedge pclk);
    rdc(12'h048, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("write slot", 32'h2, {28'h0, q[3:0]});
  endtask
  task automatic t_block_first;
    want_blk[1] <= 1'b1;
    repeat (20) @(posedge pclk);
    want_pick[1] <= 1'b1;
    wait_cond(1, efsbl_pkg::COND_BLOCKED);
    repeat (4) @(posedge pclk);
    rdc(12'h04c, 32'h0);
  endtask
  task automatic t_trip;
    apb(1'b1, 12'h148, 32'h2);
    want_pick[2] <= 1'b1;
    wait_cond(2, efsbl_pkg::COND_TRIPPED);
    chk("trip parts", 32'h2, {30'h0, rt[2], xt[2]});
    repeat (4) @(posedge pclk);
    rdc(12'h05c, 32'h1);
    rdc(12'h044, 32'h0);
  endtask
  task automatic t_inrush;
    harm[3] <= 13'h0014;
    want_pick[3] <= 1'b1;
    wait_cond(3, efsbl_pkg::COND_STARTED);
    chk("start parts", 32'h1, {30'h0, rs[3], xs[3]});
    apb(1'b1, 12'h164, 32'h14);
    apb(1'b1, 12'h160, 32'h1);
    wait_cond(3, efsbl_pkg::COND_BLOCKED);
  endtask
  task automatic t_inverse;
    apb(1'b1, 12'h120, 32'h2);
    apb(1'b1, 12'h128, 32'h2);
    apb(1'b1, 12'h12c, 32'h3);
    want_blk[1] <= 1'b0;
    wait_cond(1, efsbl_pkg::COND_STARTED);
    repeat (12) @(posedge pclk);
    chk("minimum time", 32'h1, {30'h0, cond_o[1]});
    wait_cond(1, efsbl_pkg::COND_TRIPPED);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want_pick = 4'h0;
    want_blk = 4'h0;
    harm = '0;
    cur = {4{8'h10}};
    meas = 16'h1234;
    grp = 3'h2;
    gnd = 2'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_start;
    t_block_late;
    t_block_first;
    t_trip;
    t_inrush;
    t_inverse;
    complete_run;
  end
endmodule
